// ===== dv/cpu_core_regs_test.sv
`timescale 1ns/1ps
module cpu_core_regs_test;
  import core_regs_pkg::*;
  logic core_clk, sys_rst, sfr_rd, sfr_hit, push_op, pop_op;
  logic acc_load, ptr_load;
  sfr_write_t sfr_wr;
  bit_write_t bit_wr;
  alu_flags_t alu_flags;
  flash_ref_t fetch_ref, const_ref;
  logic [7:0] sfr_rd_addr, sfr_rdata, acc_value, stack_top_pointer;
  logic [7:0] arith_primary_reg, second_operand_register;
  logic [7:0] program_status_word, code_bank_select_reg;
  logic [15:0] ptr_value, exec_pc, const_addr, indirect_pointer, a, b;
  logic [4:0] reg_bank_base;
  logic [7:0] acc_exp, psw_exp;
  logic [7:0] vals [5];
  logic [7:0] rw_addr [5];
  logic [31:0] f;
  int err_total;
  int compares;

  cpu_core_regs i_cpu_core_regs (
    .core_clk, .sys_rst, .sfr_wr, .bit_wr, .sfr_rd, .sfr_rd_addr,
    .sfr_rdata, .sfr_hit, .push_op, .pop_op, .acc_load, .acc_value,
    .ptr_load, .ptr_value, .alu_flags, .exec_pc, .const_addr,
    .fetch_ref, .const_ref, .indirect_pointer, .stack_top_pointer,
    .arith_primary_reg, .second_operand_register,
    .program_status_word, .reg_bank_base, .code_bank_select_reg
  );

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Ends every operation: take the edge, drop all strobes, settle
  task automatic done;
    @(posedge core_clk);
    push_op <= 1'b0;
    pop_op <= 1'b0;
    acc_load <= 1'b0;
    ptr_load <= 1'b0;
    alu_flags <= '0;
    sfr_wr.wr <= 1'b0;
    bit_wr.wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1;
  endtask

  task automatic wr_byte(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    sfr_wr <= '{1'b1, ad, d};
    done;
  endtask

  task automatic wr_bit(input logic [7:0] ad, input logic d);
    @(posedge core_clk);
    bit_wr <= '{1'b1, ad, d};
    done;
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e,
                        input logic h);
    @(posedge core_clk);
    sfr_rd <= 1'b1;
    sfr_rd_addr <= ad;
    done;
    chk(sfr_rdata, e);
    chk(sfr_hit, h);
  endtask

  // Upper window takes the chosen bank, lower window is always bank 0
  function automatic logic [18:0] map_exp(input logic [15:0] ad,
                                          input logic [1:0] bk);
    logic [16:0] fa;
    fa = {ad[15] ? bk : 2'b00, ad[14:0]};
    return {fa, fa == 17'h1_ffff, 1'b0};
  endfunction

  task automatic end_of_test;
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    end_of_test;
  end

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    err_total = 0;
    compares = 0;
    sys_rst = 1'b1;
    sfr_wr = '0;
    bit_wr = '0;
    sfr_rd = 1'b0;
    sfr_rd_addr = 8'h00;
    {push_op, pop_op, acc_load, ptr_load} = 4'h0;
    acc_value = 8'h00;
    ptr_value = 16'h0000;
    alu_flags = '0;
    exec_pc = 16'h0000;
    const_addr = 16'h0000;
    rw_addr = '{SP_ADDR, DPL_ADDR, DPH_ADDR, ACC_ADDR, B_ADDR};
    void'($urandom(32'h562c6a8f));
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk(stack_top_pointer, SP_RST);
    chk(indirect_pointer, 16'h0000);
    chk(arith_primary_reg, 8'h00);
    chk(second_operand_register, 8'h00);
    chk(program_status_word, 8'h00);
    chk(code_bank_select_reg, BANKSEL_RST);
    rd_chk(SP_ADDR, SP_RST, 1'b1);
    rd_chk(8'h85, 8'h00, 1'b0);
    // Random byte traffic, back-read over the register bus
    repeat (8) begin
      for (int i = 0; i < 5; i++) begin
        vals[i] = 8'($urandom);
        wr_byte(rw_addr[i], vals[i]);
      end
      for (int i = 0; i < 5; i++) begin
        rd_chk(rw_addr[i], vals[i], 1'b1);
      end
      chk(stack_top_pointer, vals[0]);
      chk(indirect_pointer, {vals[2], vals[1]});
      chk(arith_primary_reg, vals[3]);
      chk(second_operand_register, vals[4]);
      chk(program_status_word[0], ^vals[3]);
    end
    // Stack: back-to-back pushes, then wrap at the top
    wr_byte(SP_ADDR, 8'h0e);
    @(posedge core_clk);
    push_op <= 1'b1;
    @(posedge core_clk);
    done;
    chk(stack_top_pointer, 8'h10);
    wr_byte(SP_ADDR, 8'hff);
    @(posedge core_clk);
    push_op <= 1'b1;
    done;
    chk(stack_top_pointer, 8'h00);
    @(posedge core_clk);
    pop_op <= 1'b1;
    done;
    chk(stack_top_pointer, 8'hff);
    // Core loads of accumulator and pointer
    repeat (16) begin
      acc_exp = 8'($urandom);
      a = 16'($urandom);
      @(posedge core_clk);
      acc_load <= 1'b1;
      acc_value <= acc_exp;
      ptr_load <= 1'b1;
      ptr_value <= a;
      done;
      chk(arith_primary_reg, acc_exp);
      chk(indirect_pointer, a);
      chk(program_status_word[0], ^acc_exp);
    end
    // Status word byte writes, every register bank code
    for (int r = 0; r < 4; r++) begin
      psw_exp = 8'($urandom);
      psw_exp[4:3] = 2'(r);
      wr_byte(PSW_ADDR, psw_exp);
      chk(reg_bank_base, {2'(r), 3'b000});
      chk(program_status_word[7:1], psw_exp[7:1]);
      chk(program_status_word[0], ^acc_exp);
    end
    // Random flag events; user flags and bank bits must survive
    repeat (24) begin
      f = $urandom;
      @(posedge core_clk);
      alu_flags <= '{f[4], f[0], f[1], f[2], f[3]};
      done;
      if (f[4]) begin
        psw_exp[7:6] = f[1:0] == 2'b10 ? 2'b01 : {f[0], f[1]};
        psw_exp[7] = f[0];
        psw_exp[6] = f[1];
      end
      if (f[2]) begin
        psw_exp[2] = f[3];
      end
      chk(program_status_word[7:1], psw_exp[7:1]);
      chk(program_status_word[2], psw_exp[2]);
    end
    // Bit writes: user flags, read-only odd-ones bit, ACC and B bits
    wr_bit(8'hd5, ~psw_exp[5]);
    wr_bit(8'hd1, ~psw_exp[1]);
    wr_bit(8'hd0, ~(^acc_exp));
    psw_exp[5] = ~psw_exp[5];
    psw_exp[1] = ~psw_exp[1];
    chk(program_status_word, {psw_exp[7:1], ^acc_exp});
    wr_bit(8'he3, ~acc_exp[3]);
    acc_exp[3] = ~acc_exp[3];
    chk(arith_primary_reg, acc_exp);
    chk(program_status_word[0], ^acc_exp);
    wr_bit(8'hf7, 1'b1);
    chk(second_operand_register[7], 1'b1);
    // Code banking: reserved bits, then every field pairing
    wr_byte(BANKSEL_ADDR, 8'hff);
    chk(code_bank_select_reg, 8'h33);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge core_clk);
        exec_pc <= 16'h0000;
        wr_byte(BANKSEL_ADDR, {2'b00, 2'(c), 2'b00, 2'(k)});
        for (int j = 0; j < 5; j++) begin
          a = j == 0 ? 16'hffff : j == 1 ? 16'h8000 : 16'($urandom);
          b = j == 0 ? 16'hffff : j == 1 ? 16'h7fff : 16'($urandom);
          @(posedge core_clk);
          exec_pc <= a;
          const_addr <= b;
          @(posedge core_clk);
          #1;
          chk(fetch_ref, map_exp(a, 2'(k)));
          chk(const_ref, map_exp(b, 2'(c)));
          if (c == k && j == 0) begin
            chk(const_ref, map_exp(a, 2'(k)));
          end
        end
      end
    end
    // Fetch field locked from upper-bank code unless bank 0 selected
    @(posedge core_clk);
    exec_pc <= 16'h0000;
    wr_byte(BANKSEL_ADDR, 8'h11);
    @(posedge core_clk);
    exec_pc <= 16'h9000;
    wr_byte(BANKSEL_ADDR, 8'h22);
    chk(code_bank_select_reg, 8'h21);
    @(posedge core_clk);
    exec_pc <= 16'h0000;
    wr_byte(BANKSEL_ADDR, 8'h00);
    @(posedge core_clk);
    exec_pc <= 16'h9000;
    wr_byte(BANKSEL_ADDR, 8'h32);
    chk(code_bank_select_reg, 8'h32);
    // Second reset in mid-run
    @(posedge core_clk);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk(stack_top_pointer, SP_RST);
    chk(code_bank_select_reg, BANKSEL_RST);
    end_of_test;
  end
endmodule

// ===== rtl/code_bank_map.sv
`timescale 1ns/1ps
module code_bank_map (
  input wire logic [15:0] cpu_addr,
  input wire logic [1:0] bank,
  output core_regs_pkg::flash_ref_t ref_out
);
  import core_regs_pkg::*;

  logic [1:0] eff_bank;
  logic [16:0] flat;

  // Lower window is always bank 0; upper follows the field
  always_comb begin
    eff_bank = BANK_ZERO;
    if (BANKED && cpu_addr[UPPER_BIT]) begin
      eff_bank = bank;
    end
    if (BANKED) begin
      flat = {eff_bank, cpu_addr[14:0]};
    end else begin
      flat = {1'b0, cpu_addr};
    end
  end

  // One driver for the whole carrier
  assign ref_out = {flat, flat == LOCK_ADDR, flat > LOCK_ADDR};
endmodule

// ===== rtl/core_regs_pkg.sv
package core_regs_pkg;

  // ------------------------------------------------
  // Register addresses, same on every page
  // ------------------------------------------------
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] DPL_ADDR = 8'h82;
  localparam logic [7:0] DPH_ADDR = 8'h83;
  localparam logic [7:0] BANKSEL_ADDR = 8'h84;
  localparam logic [7:0] PSW_ADDR = 8'hd0;
  localparam logic [7:0] ACC_ADDR = 8'he0;
  localparam logic [7:0] B_ADDR = 8'hf0;

  // ------------------------------------------------
  // Reset values, masks and stack step
  // ------------------------------------------------
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [7:0] BANKSEL_RST = 8'h11;
  localparam logic [7:0] BANKSEL_MASK = 8'h33;
  localparam logic [7:0] SP_STEP = 8'h01;

  // ------------------------------------------------
  // Field positions
  // ------------------------------------------------
  localparam int CY_BIT = 7;
  localparam int AC_BIT = 6;
  localparam int F0_BIT = 5;
  localparam int RS_HI = 4;
  localparam int RS_LO = 3;
  localparam int OV_BIT = 2;
  localparam int F1_BIT = 1;
  localparam int PAR_BIT = 0;
  localparam int CONST_HI = 5;
  localparam int CONST_LO = 4;
  localparam int FETCH_HI = 1;
  localparam int FETCH_LO = 0;
  localparam int UPPER_BIT = 15;

  // ------------------------------------------------
  // Flash size option
  // ------------------------------------------------
  localparam int FLASH_KB = 128;
  localparam int BANKED_MIN_KB = 64;
  localparam bit BANKED = FLASH_KB > BANKED_MIN_KB;
  localparam int FLASH_BYTES = FLASH_KB * 1024;
  localparam logic [16:0] LOCK_ADDR = 17'(FLASH_BYTES - 1);
  localparam logic [1:0] BANK_ZERO = 2'h0;

  // ------------------------------------------------
  // Carriers
  // ------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } sfr_write_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic val;
  } bit_write_t;

  typedef struct packed {
    logic arith;
    logic cy;
    logic ac;
    logic ov_op;
    logic ov;
  } alu_flags_t;

  typedef struct packed {
    logic [16:0] addr;
    logic lock;
    logic rsvd;
  } flash_ref_t;

endpackage

// ===== rtl/cpu_core_regs.sv
`timescale 1ns/1ps
module cpu_core_regs (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire core_regs_pkg::sfr_write_t sfr_wr,
  input wire core_regs_pkg::bit_write_t bit_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rd_addr,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic push_op,
  input wire logic pop_op,
  input wire logic acc_load,
  input wire logic [7:0] acc_value,
  input wire logic ptr_load,
  input wire logic [15:0] ptr_value,
  input wire core_regs_pkg::alu_flags_t alu_flags,
  input wire logic [15:0] exec_pc,
  input wire logic [15:0] const_addr,
  output core_regs_pkg::flash_ref_t fetch_ref,
  output core_regs_pkg::flash_ref_t const_ref,
  output logic [15:0] indirect_pointer,
  output logic [7:0] stack_top_pointer,
  output logic [7:0] arith_primary_reg,
  output logic [7:0] second_operand_register,
  output logic [7:0] program_status_word,
  output logic [4:0] reg_bank_base,
  output logic [7:0] code_bank_select_reg
);
  import core_regs_pkg::*;

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  // Byte write, then single-bit write for registers
  // on an 8-aligned address
  function automatic logic [7:0] merge(
    input logic [7:0] old,
    input logic [7:0] base,
    input sfr_write_t w,
    input bit_write_t bw
  );
    logic [7:0] v;
    v = old;
    if (w.wr && w.addr == base) begin
      v = w.data;
    end
    if (bw.wr && base[2:0] == 3'h0 &&
        bw.addr[7:3] == base[7:3]) begin
      v[bw.addr[2:0]] = bw.val;
    end
    return v;
  endfunction

  function automatic logic hits(
    input logic [7:0] base,
    input sfr_write_t w,
    input bit_write_t bw
  );
    return (w.wr && w.addr == base) ||
           (bw.wr && bw.addr[7:3] == base[7:3]);
  endfunction

  // ------------------------------------------------
  // Storage
  // ------------------------------------------------
  logic [7:0] pointer_low_byte;
  logic [7:0] pointer_high_byte;
  logic [7:0] status_store;
  logic [7:0] next_status;
  logic [7:0] next_banksel;
  logic [1:0] fetch_bank_sel;
  logic [1:0] const_bank_sel;
  logic odd_ones;
  logic in_bank0;
  logic [7:0] next_rdata;
  logic next_hit;

  // ------------------------------------------------
  // Indirect pointer
  // ------------------------------------------------
  // Whole-word load from the core beats byte writes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pointer_low_byte <= ZERO_RST;
      pointer_high_byte <= ZERO_RST;
    end else if (ptr_load) begin
      pointer_low_byte <= ptr_value[7:0];
      pointer_high_byte <= ptr_value[15:8];
    end else begin
      pointer_low_byte <= merge(pointer_low_byte, DPL_ADDR,
                                sfr_wr, bit_wr);
      pointer_high_byte <= merge(pointer_high_byte, DPH_ADDR,
                                 sfr_wr, bit_wr);
    end
  end

  // Data moves use the pointer as a data-space address
  assign indirect_pointer = {pointer_high_byte,
                             pointer_low_byte};

  // ------------------------------------------------
  // Stack pointer
  // ------------------------------------------------
  // Push and pop win over a software write in the same
  // cycle; the core never issues both together
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_top_pointer <= SP_RST;
    end else if (push_op) begin
      // Caller stores at the new value next cycle
      stack_top_pointer <= stack_top_pointer + SP_STEP;
    end else if (pop_op) begin
      stack_top_pointer <= stack_top_pointer - SP_STEP;
    end else begin
      stack_top_pointer <= merge(stack_top_pointer, SP_ADDR,
                                 sfr_wr, bit_wr);
    end
  end

  // ------------------------------------------------
  // Accumulator and second register
  // ------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arith_primary_reg <= ZERO_RST;
    end else if (acc_load) begin
      arith_primary_reg <= acc_value;
    end else begin
      arith_primary_reg <= merge(arith_primary_reg, ACC_ADDR,
                                 sfr_wr, bit_wr);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      second_operand_register <= ZERO_RST;
    end else begin
      second_operand_register <= merge(second_operand_register,
                                       B_ADDR, sfr_wr,
                                       bit_wr);
    end
  end

  odd_ones_detect u_odd (
    .value(arith_primary_reg),
    .odd(odd_ones)
  );

  // ------------------------------------------------
  // Program status word
  // ------------------------------------------------
  // Arithmetic results win over a software write so a
  // flag event is never lost
  always_comb begin
    next_status = merge(status_store, PSW_ADDR, sfr_wr, bit_wr);
    if (alu_flags.arith) begin
      next_status[CY_BIT] = alu_flags.cy;
      next_status[AC_BIT] = alu_flags.ac;
    end
    if (alu_flags.ov_op) begin
      // Set or cleared by the operation's own result
      next_status[OV_BIT] = alu_flags.ov;
    end
    next_status[PAR_BIT] = 1'b0;
  end

  // User flags only move through the merge above
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_store <= ZERO_RST;
    end else begin
      status_store <= next_status;
    end
  end

  // Stored bit 0 is unused; read side shows the gates
  always_comb begin
    program_status_word = status_store;
    program_status_word[PAR_BIT] = odd_ones;
  end

  assign reg_bank_base = {status_store[RS_HI:RS_LO],
                          3'h0};

  // ------------------------------------------------
  // Code bank select
  // ------------------------------------------------
  // Running from bank 0 means lower window, or upper
  // window while the fetch field names bank 0
  assign in_bank0 = !exec_pc[UPPER_BIT] ||
                    fetch_bank_sel == BANK_ZERO;

  always_comb begin
    next_banksel = merge(code_bank_select_reg, BANKSEL_ADDR,
                         sfr_wr, bit_wr) & BANKSEL_MASK;
    if (!in_bank0) begin
      next_banksel[FETCH_HI:FETCH_LO] = fetch_bank_sel;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_bank_select_reg <= BANKSEL_RST;
    end else begin
      code_bank_select_reg <= next_banksel;
    end
  end

  assign fetch_bank_sel =
    code_bank_select_reg[FETCH_HI:FETCH_LO];
  assign const_bank_sel =
    code_bank_select_reg[CONST_HI:CONST_LO];

  // ------------------------------------------------
  // Flash address mapping
  // ------------------------------------------------
  // Two mappers: fetches and constant reads may sit in
  // different upper banks at once
  code_bank_map u_fetch_map (
    .cpu_addr(exec_pc),
    .bank(fetch_bank_sel),
    .ref_out(fetch_ref)
  );

  // PC-relative code loads arrive here too, so they
  // follow the constant field, not the fetch field
  code_bank_map u_const_map (
    .cpu_addr(const_addr),
    .bank(const_bank_sel),
    .ref_out(const_ref)
  );

  // ------------------------------------------------
  // Register read port
  // ------------------------------------------------
  // No page input: these addresses decode on all pages
  always_comb begin
    next_hit = 1'b1;
    case (sfr_rd_addr)
      SP_ADDR: next_rdata = stack_top_pointer;
      DPL_ADDR: next_rdata = pointer_low_byte;
      DPH_ADDR: next_rdata = pointer_high_byte;
      BANKSEL_ADDR: next_rdata = code_bank_select_reg;
      PSW_ADDR: next_rdata = program_status_word;
      ACC_ADDR: next_rdata = arith_primary_reg;
      B_ADDR: next_rdata = second_operand_register;
      default: begin
        next_rdata = ZERO_RST;
        next_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= ZERO_RST;
      sfr_hit <= 1'b0;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
      sfr_hit <= next_hit;
    end else begin
      sfr_hit <= 1'b0;
    end
  end

  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  logic psw_touched;
  assign psw_touched = hits(PSW_ADDR, sfr_wr, bit_wr);

  a_sp_reset_value: assert property (
    $past(sys_rst) |-> stack_top_pointer == SP_RST
  ) else $error("stack pointer not at reset value");

  a_push_pre_incr: assert property (
    push_op |=> stack_top_pointer ==
                $past(stack_top_pointer) + SP_STEP
  ) else $error("push did not increment stack pointer");

  a_pointer_load: assert property (
    ptr_load |=> indirect_pointer == $past(ptr_value)
  ) else $error("pointer load lost");

  a_carry_update: assert property (
    alu_flags.arith |=>
      program_status_word[CY_BIT] == $past(alu_flags.cy)
  ) else $error("carry flag not updated");

  a_half_carry_upd: assert property (
    alu_flags.arith |=>
      program_status_word[AC_BIT] == $past(alu_flags.ac)
  ) else $error("half carry flag not updated");

  a_user_flags_hold: assert property (
    !psw_touched |=>
      $stable(program_status_word[F0_BIT]) &&
      $stable(program_status_word[F1_BIT])
  ) else $error("user flag changed without software");

  a_bank_base_map: assert property (
    sfr_wr.wr && sfr_wr.addr == PSW_ADDR |=>
      reg_bank_base == {$past(sfr_wr.data[RS_HI:RS_LO]), 3'h0}
  ) else $error("working bank base wrong");

  a_overflow_update: assert property (
    alu_flags.ov_op |=>
      program_status_word[OV_BIT] == $past(alu_flags.ov)
  ) else $error("overflow flag not updated");

  a_odd_ones_track: assert property (
    acc_load |=>
      program_status_word[PAR_BIT] == ^$past(acc_value)
  ) else $error("odd-ones bit wrong");

  a_fetch_lockout: assert property (
    !in_bank0 |=> $stable(fetch_bank_sel)
  ) else $error("fetch bank changed from upper bank");

  a_lower_is_bank0: assert property (
    !exec_pc[UPPER_BIT] |-> fetch_ref.addr[16:15] == BANK_ZERO
  ) else $error("lower window not bank zero");

  a_const_window: assert property (
    const_addr[UPPER_BIT] |->
      const_ref.addr[16:15] == const_bank_sel
  ) else $error("constant access used wrong bank");

  a_read_answer: assert property (
    sfr_rd && sfr_rd_addr == SP_ADDR |=>
      sfr_hit && sfr_rdata == $past(stack_top_pointer)
  ) else $error("stack pointer read wrong");

endmodule

// ===== rtl/odd_ones_detect.sv
`timescale 1ns/1ps
module odd_ones_detect (
  input wire logic [7:0] value,
  output logic odd
);
  // Pure gates so the flag tracks the value with no lag
  assign odd = ^value;
endmodule
